// File: rtl/ivpr_pkg.sv
/*
 * Shared constants for the interrupt vector and priority resolver:
 * register offsets, field positions, reset values, fixed vectors and levels,
 * source identifiers and the acceptance sequencer states.
 * Assumes a 32-bit APB register bus and a 4-bit core interrupt mask level.
 */
package ivpr_pkg;

	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LVL_W = 5;
	localparam int MASK_W = 4;
	localparam int VEC_W = 7;
	localparam int SRC_W = 3;
	localparam int NSRC = 6;
	localparam int EVT_W = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_VECTOR_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PRIORITY_SETTING = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DMA0_VECTOR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DMA1_VECTOR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_ACCEPTED = 8'h18;

	// Field positions
	localparam int DMA_PRIO_LSB = 8;
	localparam int ACC_MASK_LSB = 8;
	localparam int ACC_SRC_LSB = 16;
	localparam int ACC_STATE_LSB = 24;

	// Reset values
	localparam logic [DATA_W-1:0] RST_VECTOR_BASE = 32'h0000_0000;
	localparam logic [MASK_W-1:0] RST_PERIPH_PRIO = 4'h0;
	localparam logic [VEC_W-1:0] RST_DMA_VECTOR = 7'h00;

	// Fixed levels and vectors
	localparam logic [LVL_W-1:0] LVL_NMI = 5'h10;
	localparam logic [LVL_W-1:0] LVL_FIXED15 = 5'h0f;
	localparam logic [LVL_W-1:0] LVL_MASKED = 5'h00;
	localparam logic [MASK_W-1:0] MASK_AFTER_NMI = 4'hf;
	localparam logic [MASK_W-1:0] ENC_IDLE_CODE = 4'hf;
	localparam logic [VEC_W-1:0] VEC_NMI = 7'h0b;
	localparam logic [VEC_W-1:0] VEC_USER_BREAK = 7'h0c;
	localparam logic [VEC_W-1:0] VEC_DEBUG = 7'h0d;
	localparam logic [VEC_W-1:0] VEC_ENC_BASE = 7'h40;

	// Source identifiers, in default tie order
	localparam logic [SRC_W-1:0] SRC_NMI = 3'h0;
	localparam logic [SRC_W-1:0] SRC_USER_BREAK = 3'h1;
	localparam logic [SRC_W-1:0] SRC_DEBUG = 3'h2;
	localparam logic [SRC_W-1:0] SRC_ENC = 3'h3;
	localparam logic [SRC_W-1:0] SRC_DMA0 = 3'h4;
	localparam logic [SRC_W-1:0] SRC_DMA1 = 3'h5;

	// Event status bits
	localparam int EVT_ACCEPT = 0;
	localparam int EVT_NMI = 1;
	localparam int EVT_FETCHED = 2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01
	} seq_state_t;

endpackage : ivpr_pkg

// File: rtl/prio_pick.sv
/*
 * One stage of the priority chain: keeps the best source seen so far unless
 * the candidate is valid and strictly higher.
 * Assumes stages are chained in default tie order, earliest stage first.
 */
`timescale 1ns/10ps
module prio_pick #(
	parameter int LW = 5,
	parameter int VW = 7,
	parameter int IW = 3
) (
	// Best so far
	input wire logic in_valid,
	input wire logic [LW-1:0] in_level,
	input wire logic [VW-1:0] in_vec,
	input wire logic [IW-1:0] in_id,
	// Candidate
	input wire logic cand_valid,
	input wire logic [LW-1:0] cand_level,
	input wire logic [VW-1:0] cand_vec,
	input wire logic [IW-1:0] cand_id,
	// Result
	output logic out_valid,
	output logic [LW-1:0] out_level,
	output logic [VW-1:0] out_vec,
	output logic [IW-1:0] out_id
);
	logic take;

	// Strict compare: an equal level keeps the earlier source
	assign take = cand_valid && (!in_valid || (cand_level > in_level));
	assign out_valid = in_valid || cand_valid;
	assign out_level = take ? cand_level : in_level;
	assign out_vec = take ? cand_vec : in_vec;
	assign out_id = take ? cand_id : in_id;

endmodule : prio_pick

// File: rtl/ivpr_top.sv
/*
 * Interrupt vector and priority resolver: ranks the pending sources, requests
 * the core, and on acceptance fetches the handler address from the vector
 * table and hands the new mask level to the core. APB register slave and a
 * sticky event status with mask drive one interrupt line.
 * Assumes level requests from break, debug and DMA stay high until acked,
 * and a memory port that answers each fetch request with one ack pulse.
 */
// The register addresses and the APB interface to the registers were decided locally.
// Notes on behaviour
// - Each source other than the encoded levels gets its own vector number, so its handler needs no source decode.
// - The handler address is read from vector base plus four times the vector number.
// - Encoded level requests 15 to 1 have fixed levels equal to their number.
// - The DMA transfer-end priority is software programmable from 0 to 15.
// - The two DMA sources share one priority field and rank channel 0 first.
// - Reset sets the peripheral priority field to level 0.
// - Equal levels resolve NMI, break, debug, encoded level, DMA0, DMA1 in that order.
// - Encoded levels share autovectors in pairs, 2 and 1 on 64 up to 14 and 13 on 70; level 15 alone is on 71.
// - A source programmed to level 0 is masked and never accepted.
// - NMI has level 16, is always accepted and loads mask level 15.
// - A peripheral acceptance loads the mask level with that source's level.
`timescale 1ns/10ps
module ivpr_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ivpr_pkg::ADDR_W-1:0] paddr,
	input wire logic [ivpr_pkg::DATA_W-1:0] pwdata,
	output logic [ivpr_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources
	input wire logic nmi_in,
	input wire logic user_break_req,
	input wire logic serial_debug_interrupt,
	input wire logic [3:0] encoded_level_request,
	input wire logic dma0_end_req,
	input wire logic dma1_end_req,
	output logic [ivpr_pkg::NSRC-1:0] src_ack,
	// Core side
	input wire logic [ivpr_pkg::MASK_W-1:0] interrupt_mask_level,
	output logic core_int_req,
	input wire logic core_ack,
	output logic mask_load,
	output logic [ivpr_pkg::MASK_W-1:0] new_mask_level,
	output logic [ivpr_pkg::DATA_W-1:0] handler_addr,
	output logic handler_valid,
	// Vector table fetch
	output logic fetch_req,
	output logic [ivpr_pkg::DATA_W-1:0] fetch_addr,
	input wire logic fetch_ack,
	input wire logic [ivpr_pkg::DATA_W-1:0] fetch_data,
	// Interrupt
	output logic irq
);
	localparam int AW = ivpr_pkg::ADDR_W;
	localparam int DW = ivpr_pkg::DATA_W;
	localparam int LW = ivpr_pkg::LVL_W;
	localparam int MW = ivpr_pkg::MASK_W;
	localparam int VW = ivpr_pkg::VEC_W;
	localparam int IW = ivpr_pkg::SRC_W;
	localparam int NS = ivpr_pkg::NSRC;
	localparam int EW = ivpr_pkg::EVT_W;

	typedef struct packed {
		ivpr_pkg::seq_state_t st;
		logic [DW-1:0] vector_base;
		logic [MW-1:0] priority_setting_regs;
		logic [VW-1:0] dma0_vector_setting;
		logic [VW-1:0] dma1_vector_setting;
		logic [EW-1:0] evt_status;
		logic [EW-1:0] evt_mask;
		logic nmi_prev;
		logic nmi_pend;
		logic int_req;
		logic [IW-1:0] acc_src;
		logic [VW-1:0] acc_vec;
		logic mask_load;
		logic [MW-1:0] new_mask;
		logic [NS-1:0] src_ack;
		logic fetch_req;
		logic [DW-1:0] fetch_addr;
		logic [DW-1:0] handler_addr;
		logic handler_valid;
		logic irq;
		logic [DW-1:0] prdata;
		logic pready;
		logic pslverr;
	} ivpr_state_t;

	ivpr_state_t st_r;
	ivpr_state_t st_nxt;

	// Candidate arrays, default tie order
	logic [NS-1:0] c_valid;
	logic [LW-1:0] c_level [NS];
	logic [VW-1:0] c_vec [NS];
	logic [IW-1:0] c_id [NS];
	logic [NS-1:0] b_valid;
	logic [LW-1:0] b_level [NS];
	logic [VW-1:0] b_vec [NS];
	logic [IW-1:0] b_id [NS];
	logic [LW-1:0] enc_level;
	logic [LW-1:0] dma_level;
	logic [VW-1:0] enc_vec;
	logic best_valid;
	logic [LW-1:0] best_level;
	logic [VW-1:0] best_vec;
	logic [IW-1:0] best_id;
	logic best_ok;
	logic take;
	logic setup;
	logic wr_acc;
	logic mapped;
	logic [EW-1:0] evt_set;

	// Encoded pins are active low: all ones is idle, all zeros is level 15
	assign enc_level = LW'(ivpr_pkg::ENC_IDLE_CODE - encoded_level_request);
	assign enc_vec = ivpr_pkg::VEC_ENC_BASE + VW'((enc_level - LW'(1)) >> 1);
	assign dma_level = LW'(st_r.priority_setting_regs);

	assign c_valid[0] = st_r.nmi_pend;
	assign c_level[0] = ivpr_pkg::LVL_NMI;
	assign c_vec[0] = ivpr_pkg::VEC_NMI;
	assign c_id[0] = ivpr_pkg::SRC_NMI;
	assign c_valid[1] = user_break_req;
	assign c_level[1] = ivpr_pkg::LVL_FIXED15;
	assign c_vec[1] = ivpr_pkg::VEC_USER_BREAK;
	assign c_id[1] = ivpr_pkg::SRC_USER_BREAK;
	assign c_valid[2] = serial_debug_interrupt;
	assign c_level[2] = ivpr_pkg::LVL_FIXED15;
	assign c_vec[2] = ivpr_pkg::VEC_DEBUG;
	assign c_id[2] = ivpr_pkg::SRC_DEBUG;
	assign c_valid[3] = (enc_level != ivpr_pkg::LVL_MASKED);
	assign c_level[3] = enc_level;
	assign c_vec[3] = enc_vec;
	assign c_id[3] = ivpr_pkg::SRC_ENC;
	// Both channels read the one shared field; chain position ranks them
	assign c_valid[4] = dma0_end_req && (dma_level != ivpr_pkg::LVL_MASKED);
	assign c_level[4] = dma_level;
	assign c_vec[4] = st_r.dma0_vector_setting;
	assign c_id[4] = ivpr_pkg::SRC_DMA0;
	assign c_valid[5] = dma1_end_req && (dma_level != ivpr_pkg::LVL_MASKED);
	assign c_level[5] = dma_level;
	assign c_vec[5] = st_r.dma1_vector_setting;
	assign c_id[5] = ivpr_pkg::SRC_DMA1;

	assign b_valid[0] = c_valid[0];
	assign b_level[0] = c_level[0];
	assign b_vec[0] = c_vec[0];
	assign b_id[0] = c_id[0];

	// Earlier stage wins ties
	genvar gi;
	generate
		for (gi = 1; gi < NS; gi++) begin : g_chain
			prio_pick #(.LW(LW), .VW(VW), .IW(IW)) u_pick (
				.in_valid(b_valid[gi-1]),
				.in_level(b_level[gi-1]),
				.in_vec(b_vec[gi-1]),
				.in_id(b_id[gi-1]),
				.cand_valid(c_valid[gi]),
				.cand_level(c_level[gi]),
				.cand_vec(c_vec[gi]),
				.cand_id(c_id[gi]),
				.out_valid(b_valid[gi]),
				.out_level(b_level[gi]),
				.out_vec(b_vec[gi]),
				.out_id(b_id[gi])
			);
		end
	endgenerate

	assign best_valid = b_valid[NS-1];
	assign best_level = b_level[NS-1];
	assign best_vec = b_vec[NS-1];
	assign best_id = b_id[NS-1];
	// NMI ignores the mask; everything else must beat it strictly
	assign best_ok = best_valid && ((best_id == ivpr_pkg::SRC_NMI) ||
		(best_level > LW'(interrupt_mask_level)));
	assign take = (st_r.st == ivpr_pkg::ST_IDLE) && st_r.int_req && core_ack && best_ok;

	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite && st_r.pready;
	assign mapped = (paddr == ivpr_pkg::OFS_VECTOR_BASE) ||
		(paddr == ivpr_pkg::OFS_PRIORITY_SETTING) ||
		(paddr == ivpr_pkg::OFS_DMA0_VECTOR) ||
		(paddr == ivpr_pkg::OFS_DMA1_VECTOR) ||
		(paddr == ivpr_pkg::OFS_EVENT_STATUS) ||
		(paddr == ivpr_pkg::OFS_EVENT_MASK) ||
		(paddr == ivpr_pkg::OFS_ACCEPTED);

	always_comb begin
		st_nxt = st_r;
		evt_set = '0;
		st_nxt.mask_load = 1'b0;
		st_nxt.src_ack = '0;
		st_nxt.handler_valid = 1'b0;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		st_nxt.nmi_prev = nmi_in;

		// Sequencer
		unique case (st_r.st)
			ivpr_pkg::ST_IDLE: begin
				st_nxt.int_req = best_ok && !take;
				if (take) begin
					st_nxt.acc_src = best_id;
					st_nxt.acc_vec = best_vec;
					st_nxt.mask_load = 1'b1;
					st_nxt.src_ack = NS'(1) << best_id;
					if (best_id == ivpr_pkg::SRC_NMI) begin
						st_nxt.new_mask = ivpr_pkg::MASK_AFTER_NMI;
						evt_set[ivpr_pkg::EVT_NMI] = 1'b1;
					end else begin
						st_nxt.new_mask = MW'(best_level);
					end
					st_nxt.fetch_req = 1'b1;
					st_nxt.fetch_addr = st_r.vector_base + {{(DW-VW-2){1'b0}}, best_vec, 2'b00};
					evt_set[ivpr_pkg::EVT_ACCEPT] = 1'b1;
					st_nxt.st = ivpr_pkg::ST_FETCH;
				end
			end
			ivpr_pkg::ST_FETCH: begin
				st_nxt.int_req = 1'b0;
				if (fetch_ack) begin
					st_nxt.fetch_req = 1'b0;
					st_nxt.handler_addr = fetch_data;
					st_nxt.handler_valid = 1'b1;
					evt_set[ivpr_pkg::EVT_FETCHED] = 1'b1;
					st_nxt.st = ivpr_pkg::ST_IDLE;
				end
			end
			default: begin
				st_nxt.st = ivpr_pkg::ST_IDLE;
			end
		endcase

		// NMI is edge detected; a new edge during its own clear keeps it pending
		if (take && (best_id == ivpr_pkg::SRC_NMI)) begin
			st_nxt.nmi_pend = 1'b0;
		end
		if (nmi_in && !st_r.nmi_prev) begin
			st_nxt.nmi_pend = 1'b1;
		end

		// APB: read data is registered in setup, one wait-free access cycle
		if (setup) begin
			st_nxt.pready = 1'b1;
			st_nxt.pslverr = !mapped;
			st_nxt.prdata = '0;
			unique case (paddr)
				ivpr_pkg::OFS_VECTOR_BASE: st_nxt.prdata = st_r.vector_base;
				ivpr_pkg::OFS_PRIORITY_SETTING:
					st_nxt.prdata[ivpr_pkg::DMA_PRIO_LSB +: MW] = st_r.priority_setting_regs;
				ivpr_pkg::OFS_DMA0_VECTOR: st_nxt.prdata[VW-1:0] = st_r.dma0_vector_setting;
				ivpr_pkg::OFS_DMA1_VECTOR: st_nxt.prdata[VW-1:0] = st_r.dma1_vector_setting;
				ivpr_pkg::OFS_EVENT_STATUS: st_nxt.prdata[EW-1:0] = st_r.evt_status;
				ivpr_pkg::OFS_EVENT_MASK: st_nxt.prdata[EW-1:0] = st_r.evt_mask;
				ivpr_pkg::OFS_ACCEPTED: begin
					st_nxt.prdata[VW-1:0] = st_r.acc_vec;
					st_nxt.prdata[ivpr_pkg::ACC_MASK_LSB +: MW] = st_r.new_mask;
					st_nxt.prdata[ivpr_pkg::ACC_SRC_LSB +: IW] = st_r.acc_src;
					st_nxt.prdata[ivpr_pkg::ACC_STATE_LSB +: 2] = st_r.st;
				end
				default: st_nxt.prdata = '0;
			endcase
		end
		if (wr_acc) begin
			unique case (paddr)
				ivpr_pkg::OFS_VECTOR_BASE: st_nxt.vector_base = pwdata;
				ivpr_pkg::OFS_PRIORITY_SETTING:
					st_nxt.priority_setting_regs = pwdata[ivpr_pkg::DMA_PRIO_LSB +: MW];
				ivpr_pkg::OFS_DMA0_VECTOR: st_nxt.dma0_vector_setting = pwdata[VW-1:0];
				ivpr_pkg::OFS_DMA1_VECTOR: st_nxt.dma1_vector_setting = pwdata[VW-1:0];
				ivpr_pkg::OFS_EVENT_STATUS:
					st_nxt.evt_status = st_r.evt_status & ~pwdata[EW-1:0];
				ivpr_pkg::OFS_EVENT_MASK: st_nxt.evt_mask = pwdata[EW-1:0];
				default: st_nxt.vector_base = st_nxt.vector_base;
			endcase
		end
		// Set after clear, so a same-cycle event survives
		st_nxt.evt_status = st_nxt.evt_status | evt_set;
		st_nxt.irq = |(st_nxt.evt_status & st_nxt.evt_mask);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.st <= ivpr_pkg::ST_IDLE;
			st_r.vector_base <= ivpr_pkg::RST_VECTOR_BASE;
			st_r.priority_setting_regs <= ivpr_pkg::RST_PERIPH_PRIO;
			st_r.dma0_vector_setting <= ivpr_pkg::RST_DMA_VECTOR;
			st_r.dma1_vector_setting <= ivpr_pkg::RST_DMA_VECTOR;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign src_ack = st_r.src_ack;
	assign core_int_req = st_r.int_req;
	assign mask_load = st_r.mask_load;
	assign new_mask_level = st_r.new_mask;
	assign handler_addr = st_r.handler_addr;
	assign handler_valid = st_r.handler_valid;
	assign fetch_req = st_r.fetch_req;
	assign fetch_addr = st_r.fetch_addr;
	assign irq = st_r.irq;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_fetch_vector_addr: assert property (take |=> fetch_req &&
		fetch_addr == $past(st_r.vector_base) + 32'(4 * int'($past(best_vec))))
		else $error("fetch address not base plus four times vector");
	a_enc_fixed_level: assert property (take && best_id == ivpr_pkg::SRC_ENC |=>
		new_mask_level == 4'(4'hf - $past(encoded_level_request)))
		else $error("encoded level acceptance loaded wrong mask");
	// Worked from the pins, not from the resolver's own level decode
	a_enc_pair_vec: assert property (take && best_id == ivpr_pkg::SRC_ENC |=>
		st_r.acc_vec == 7'(64 + (14 - int'($past(encoded_level_request))) / 2))
		else $error("encoded level autovector wrong");
	a_prio_reset_zero: assert property ($past(rst) |-> st_r.priority_setting_regs == 4'h0)
		else $error("peripheral priority not zero after reset");
	a_masked_never: assert property (take |-> !((best_id == ivpr_pkg::SRC_DMA0 ||
		best_id == ivpr_pkg::SRC_DMA1) && st_r.priority_setting_regs == 4'h0))
		else $error("level zero source accepted");
	a_dma_chan_order: assert property (take && dma0_end_req && dma1_end_req &&
		best_id[2] |=> st_r.acc_src == ivpr_pkg::SRC_DMA0)
		else $error("dma channel 1 ranked before channel 0");
	a_nmi_mask_15: assert property (take && st_r.nmi_pend |=>
		st_r.acc_src == ivpr_pkg::SRC_NMI && mask_load && new_mask_level == 4'hf)
		else $error("nmi not taken first or mask not 15");
	a_tie_default: assert property (take && user_break_req && !st_r.nmi_pend |=>
		st_r.acc_src == ivpr_pkg::SRC_USER_BREAK)
		else $error("tie order not respected");
	a_periph_mask: assert property (take && best_id == ivpr_pkg::SRC_DMA1 |=>
		new_mask_level == $past(st_r.priority_setting_regs))
		else $error("peripheral mask level wrong");
	a_req_above_mask: assert property (core_int_req && !st_r.src_ack[0] |->
		$past(st_r.nmi_pend) || $past(best_level) > 5'($past(interrupt_mask_level)))
		else $error("request not above mask");
	a_distinct_dma_vec: assert property (take && best_id == ivpr_pkg::SRC_DMA1 |=>
		st_r.acc_vec == $past(st_r.dma1_vector_setting))
		else $error("dma1 vector not its own");
	a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

	c_nmi_accept: cover property (take && best_id == ivpr_pkg::SRC_NMI ##[1:20] handler_valid);
	c_enc_accept: cover property (take && best_id == ivpr_pkg::SRC_ENC);
	c_dma1_accept: cover property (take && best_id == ivpr_pkg::SRC_DMA1);
	c_bad_addr: cover property (pready && pslverr);

endmodule : ivpr_top

// File: bench/core_partner.sv
/*
 * Core-side partner of the resolver: takes requests, loads the mask level
 * and answers vector-table fetches promptly or slowly.
 * Assumes the resolver's registered handshake outputs and one shared clock.
 */
`timescale 1ns/10ps
module core_partner (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bench control
	input wire logic [3:0] base_mask,
	input wire logic slow,
	// Resolver side
	input wire logic core_int_req,
	output logic core_ack,
	input wire logic mask_load,
	input wire logic [3:0] new_mask_level,
	input wire logic handler_valid,
	output logic [3:0] interrupt_mask_level,
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	output logic fetch_ack,
	output logic [31:0] fetch_data
);
	logic busy_r;
	logic in_isr_r;
	logic [3:0] mask_r;
	logic [2:0] wait_r;
	// Table entry modelled as address plus a fixed offset
	wire logic [31:0] entry = fetch_addr + 32'h1000_0000;
	assign interrupt_mask_level = in_isr_r ? mask_r : base_mask;
	// Inverse outside the answer cycle, so stale data is never read as good
	assign fetch_data = fetch_ack ? entry : ~entry;
	always @(posedge sys_clk) begin
		if (rst) begin
			core_ack <= 1'b0;
			busy_r <= 1'b0;
			in_isr_r <= 1'b0;
			mask_r <= 4'h0;
			wait_r <= 3'h0;
			fetch_ack <= 1'b0;
		end else begin
			core_ack <= core_int_req && !busy_r && !core_ack;
			// Busy only once accepted: a refused ack must not stall the model
			if (mask_load) busy_r <= 1'b1;
			if (mask_load) begin
				mask_r <= new_mask_level;
				in_isr_r <= 1'b1;
			end
			if (handler_valid) begin
				busy_r <= 1'b0;
				in_isr_r <= 1'b0;
			end
			fetch_ack <= 1'b0;
			if (fetch_req && !fetch_ack) begin
				wait_r <= wait_r + 3'h1;
				if (wait_r >= (slow ? 3'h5 : 3'h0)) begin
					fetch_ack <= 1'b1;
					wait_r <= 3'h0;
				end
			end
		end
	end
endmodule : core_partner

// File: bench/test_interrupt_vector_priority_resolver.sv
/*
 * Self-checking bench for the resolver: queue model of acceptances,
 * APB master, core partner model.
 * Assumes the resolver's one-cycle APB answer and registered pulses.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_interrupt_vector_priority_resolver;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, fetch_addr, fetch_data, handler_addr;
	logic pready, pslverr, core_int_req, core_ack, mask_load, handler_valid;
	logic fetch_req, fetch_ack, irq, nmi_in = 1'b0, user_break_req = 1'b0;
	logic serial_debug_interrupt = 1'b0, dma0_end_req = 1'b0, dma1_end_req = 1'b0;
	logic [3:0] encoded_level_request = 4'hf, interrupt_mask_level, new_mask_level;
	logic [3:0] base_mask = 4'h0;
	logic slow = 1'b0;
	logic [5:0] src_ack, ack_s = 6'h0;
	logic [31:0] vb_m = 32'h0, exp_h = 32'h0;
	logic [6:0] dv0_m = 7'h0, dv1_m = 7'h0;
	int n_mismatch = 0, total_checks = 0, cycles = 0, n_handled = 0, goal = 0;
	int q_vec[$], q_mask[$], q_src[$];
	int ev, em, es, lv, seed;
	always #4 sys_clk = ~sys_clk;
	ivpr_top u_ivpr_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_in(nmi_in), .user_break_req(user_break_req),
		.serial_debug_interrupt(serial_debug_interrupt),
		.encoded_level_request(encoded_level_request), .dma0_end_req(dma0_end_req),
		.dma1_end_req(dma1_end_req), .src_ack(src_ack),
		.interrupt_mask_level(interrupt_mask_level), .core_int_req(core_int_req),
		.core_ack(core_ack), .mask_load(mask_load), .new_mask_level(new_mask_level),
		.handler_addr(handler_addr), .handler_valid(handler_valid), .fetch_req(fetch_req),
		.fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .irq(irq));
	core_partner u_core_partner (.sys_clk(sys_clk), .rst(rst), .base_mask(base_mask),
		.slow(slow), .core_int_req(core_int_req), .core_ack(core_ack),
		.mask_load(mask_load), .new_mask_level(new_mask_level),
		.handler_valid(handler_valid), .interrupt_mask_level(interrupt_mask_level),
		.fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
		.fetch_data(fetch_data));
	function automatic int vec_of(int s, int l);
		case (s)
			0: return 11;
			1: return 12;
			2: return 13;
			3: return 64 + (l - 1) / 2;
			4: return dv0_m;
			default: return dv1_m;
		endcase
	endfunction : vec_of
	task automatic expect_acc(input int s, input int l);
		q_vec.push_back(vec_of(s, l));
		q_mask.push_back((s < 3) ? 15 : l);
		q_src.push_back(s);
		goal++;
	endtask : expect_acc
	// Model compares every acceptance and every handler hand-over
	always @(negedge sys_clk) begin
		ack_s <= src_ack;
		if (mask_load === 1'b1) begin
			if (q_vec.size() == 0) begin
				`CHK("acceptance", 1, 0)
			end else begin
				ev = q_vec.pop_front();
				em = q_mask.pop_front();
				es = q_src.pop_front();
				`CHK("new_mask_level", em, new_mask_level)
				`CHK("fetch_addr", vb_m + 4 * ev, fetch_addr)
				`CHK("src_ack", 1 << es, src_ack)
				exp_h = vb_m + 4 * ev + 32'h1000_0000;
			end
		end
		if (handler_valid === 1'b1) begin
			`CHK("handler_addr", exp_h, handler_addr)
			n_handled++;
		end
	end
	// Level sources let go once acknowledged
	always @(posedge sys_clk) begin
		if (ack_s[0]) nmi_in <= 1'b0;
		if (ack_s[1]) user_break_req <= 1'b0;
		if (ack_s[2]) serial_debug_interrupt <= 1'b0;
		if (ack_s[3]) encoded_level_request <= 4'hf;
		if (ack_s[4]) dma0_end_req <= 1'b0;
		if (ack_s[5]) dma1_end_req <= 1'b0;
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		// Ready and read data are taken at the rising edge that ends the access
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input logic ee,
		input string nm);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		`CHK(nm, ex, rd)
		`CHK("pslverr", ee, er)
	endtask : rchk
	task automatic settle();
		int n;
		n = 0;
		while ((n_handled < goal || q_vec.size() != 0) && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("handled", goal, n_handled)
		repeat (4) @(posedge sys_clk);
	endtask : settle
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	initial begin
		seed = $urandom(8);
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(8'h00, 32'h0, 1'b0, "vector base");
		rchk(8'h04, 32'h0, 1'b0, "priority setting");
		rchk(8'h08, 32'h0, 1'b0, "dma0 vector");
		rchk(8'h0c, 32'h0, 1'b0, "dma1 vector");
		rchk(8'h20, 32'h0, 1'b1, "unmapped");
		vb_m = $urandom & 32'h0fff_fffc;
		dv0_m = 7'h50 + 7'($urandom % 8);
		dv1_m = 7'h60 + 7'($urandom % 8);
		wreg(8'h00, vb_m);
		wreg(8'h08, {25'h0, dv0_m});
		wreg(8'h0c, {25'h0, dv1_m});
		rchk(8'h00, vb_m, 1'b0, "vector base");
		$display("test registers done");
		for (int l = 15; l >= 1; l--) begin
			slow <= 1'($urandom % 2);
			expect_acc(3, l);
			encoded_level_request <= 4'(15 - l);
			settle();
		end
		$display("test encoded levels done");
		base_mask <= 4'h5;
		encoded_level_request <= 4'(15 - 5);
		repeat (40) @(posedge sys_clk);
		`CHK("core_int_req", 1'b0, core_int_req)
		expect_acc(3, 6);
		encoded_level_request <= 4'(15 - 6);
		settle();
		base_mask <= 4'hf;
		expect_acc(0, 16);
		nmi_in <= 1'b1;
		settle();
		base_mask <= 4'h0;
		$display("test mask level done");
		wreg(8'h04, 32'h0000_0f00);
		for (int s = 0; s < 6; s++) expect_acc(s, (s == 0) ? 16 : 15);
		nmi_in <= 1'b1;
		user_break_req <= 1'b1;
		serial_debug_interrupt <= 1'b1;
		encoded_level_request <= 4'h0;
		dma0_end_req <= 1'b1;
		dma1_end_req <= 1'b1;
		settle();
		$display("test tie order done");
		rchk(8'h10, 32'h7, 1'b0, "event status");
		`CHK("irq", 1'b0, irq)
		wreg(8'h14, 32'h7);
		repeat (2) @(posedge sys_clk);
		`CHK("irq", 1'b1, irq)
		rchk(8'h18, (5 << 16) | (15 << 8) | dv1_m, 1'b0, "accepted");
		wreg(8'h10, 32'h7);
		rchk(8'h10, 32'h0, 1'b0, "event status");
		`CHK("irq", 1'b0, irq)
		$display("test events done");
		for (int i = 0; i < 4; i++) begin
			lv = (i == 0) ? 1 : (i == 1) ? 15 : 2 + $urandom % 13;
			wreg(8'h04, lv << 8);
			expect_acc(4 + i % 2, lv);
			if (i % 2) dma1_end_req <= 1'b1;
			else dma0_end_req <= 1'b1;
			settle();
		end
		wreg(8'h04, 32'h0);
		dma0_end_req <= 1'b1;
		repeat (40) @(posedge sys_clk);
		`CHK("core_int_req", 1'b0, core_int_req)
		dma0_end_req <= 1'b0;
		$display("test dma levels done");
		conclude();
	end
endmodule : test_interrupt_vector_priority_resolver
